/* nv_pkg.sv */
package nv_pkg;

  // Register byte addresses on the bus, one aligned word each
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_LOC = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_UNLOCK = 8'h0c;
  localparam logic [7:0] ADDR_FLAG = 8'h10;

  // Control register field positions
  localparam int CTRL_FETCH = 0;
  localparam int CTRL_PROG = 1;
  localparam int CTRL_PERMIT = 2;
  localparam int CTRL_ABORT = 3;

  // Flag register field position
  localparam int FLAG_DONE = 0;

  // Array geometry
  localparam int LOC_W = 8;
  localparam int ARRAY_DEPTH = 256;

  // Unlock keys and fixed byte, field and word values
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] ZERO_NIBBLE = 4'h0;
  localparam logic [6:0] ZERO_SEVEN = 7'h00;
  localparam logic [23:0] ZERO_UPPER = 24'h000000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;

  // Timing: program time in microseconds, clock in MHz
  localparam int CLK_MHZ = 40;
  localparam int PROG_TIME_US = 5;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  // One more than the most idle cycles allowed between two steps of the unlock sequence
  localparam int UNLOCK_GAP_CYC = 4;
  localparam int CNT_W = 16;
  localparam int GAP_W = 8;

  // Unlock sequencer states
  typedef enum logic [1:0] {
    UNL_IDLE = 2'b00,
    UNL_KEY1 = 2'b01,
    UNL_ARMED = 2'b10
  } unlock_t;

endpackage

/* nv_access.sv */
// Behaviour
// [R1] 256-byte array addressed by 8-bit location register
// [R2] Program erases location then stores new byte
// [R3] Internal timer ends program; start bit clears
// [R4] Protected: CPU works, programmer reads zeros
// [R5] Fetch/program bits set-only; hardware clears them
// [R6] Permit bit 2 gates programming; zero after power-up
// [R7] Abort bit 3 set by reset mid-program
// [R8] Any reset clears location and data registers
// [R9] Done flag set on completion; software clears
// [R10] Unlock port stores nothing, reads zero
// [R11] Software leaves registers alone while programming
// [R12] Control bits 7..4 read zero
// [R13] Fetch loads data register next cycle
// [R14] Data register holds until fetch or write
// [R15] Program-start bit 1 reads one while busy
// [R16] Program needs 55h, AAh, then start bit
// [R17] Start bit refused while permit is zero
// [R18] Permit unaffected by hardware; clearing mid-program harmless (here any pin, watchdog or supply-dip reset clears permit)
// [R19] Program time is a parameterised cycle count
// [R20] Reset mid-program aborts, records abort flag
//
// The address map and register access over Wishbone were chosen for this implementation.
module nv_access #(
  parameter int PROG_CYC = nv_pkg::PROG_CYCLES,
  parameter int GAP_CYC = nv_pkg::UNLOCK_GAP_CYC
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic PIN_RESET_IN,
  input wire logic WATCHDOG_RESET_IN,
  input wire logic SUPPLY_DIP_RESET_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic PROTECT_IN,
  input wire logic PROG_RD_IN,
  input wire logic [7:0] PROG_ADDR_IN,
  output logic [7:0] PROG_DATA_OUT,
  output logic PROGRAM_DONE_OUT,
  output logic BUSY_OUT
);

  // Address compare, used for every register decode
  function automatic logic addr_is(input logic [7:0] adr, input logic [7:0] off);
    addr_is = (adr == off);
  endfunction

  logic [7:0] mem [nv_pkg::ARRAY_DEPTH]; // [R1]

  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic [7:0] loc_q;
  logic [7:0] loc_d;
  logic fetch_q;
  logic fetch_d;
  logic prog_q;
  logic prog_d;
  logic permit_q;
  logic permit_d;
  logic abort_q;
  logic abort_d;
  logic done_q;
  logic done_d;
  logic [nv_pkg::CNT_W-1:0] cnt_q;
  logic [nv_pkg::CNT_W-1:0] cnt_d;
  logic [7:0] prog_loc_q;
  logic [7:0] prog_dat_q;
  logic [7:0] pgm_out_q;
  logic [nv_pkg::GAP_W-1:0] gap_q;
  logic [nv_pkg::GAP_W-1:0] gap_d;
  nv_pkg::unlock_t unl_q;
  nv_pkg::unlock_t unl_d;

  // Bus request decode
  wire dev_rst = PIN_RESET_IN | WATCHDOG_RESET_IN | SUPPLY_DIP_RESET_IN;
  wire req = WB_CYC_IN & WB_STB_IN;
  wire take = req & ack_q;
  wire wr_take = take & WB_WE_IN & WB_SEL_IN[0];
  wire [7:0] wdat = WB_DAT_IN[7:0];
  wire hit_data = addr_is(WB_ADR_IN, nv_pkg::ADDR_DATA);
  wire hit_loc = addr_is(WB_ADR_IN, nv_pkg::ADDR_LOC);
  wire hit_ctrl = addr_is(WB_ADR_IN, nv_pkg::ADDR_CTRL);
  wire hit_unlock = addr_is(WB_ADR_IN, nv_pkg::ADDR_UNLOCK);
  wire hit_flag = addr_is(WB_ADR_IN, nv_pkg::ADDR_FLAG);
  wire wr_data = wr_take & hit_data;
  wire wr_loc = wr_take & hit_loc;
  wire wr_ctrl = wr_take & hit_ctrl;
  wire wr_unlock = wr_take & hit_unlock;
  wire wr_flag = wr_take & hit_flag;

  // Unlock step timing and program start qualification
  wire gap_ok = (gap_q < GAP_CYC[nv_pkg::GAP_W-1:0]);
  wire key1 = wr_unlock & (wdat == nv_pkg::UNLOCK_KEY1);
  wire key2 = wr_unlock & (wdat == nv_pkg::UNLOCK_KEY2);
  wire start_req = wr_ctrl & wdat[nv_pkg::CTRL_PROG];
  wire armed = (unl_q == nv_pkg::UNL_ARMED) & gap_ok; // [R16]
  wire prog_start = start_req & armed & permit_q & ~prog_q & ~dev_rst; // [R16] [R17]
  wire prog_end = prog_q & (cnt_q == nv_pkg::CNT_W'(PROG_CYC - 1)); // [R3] [R19]
  wire prog_cut = prog_q & dev_rst; // [R20]

  // Read data selection; the unlock port has no storage behind it
  wire [7:0] ctrl_rd = {nv_pkg::ZERO_NIBBLE, abort_q, permit_q, prog_q, fetch_q}; // [R12]
  wire [7:0] rd_byte = hit_data ? data_q :
                       hit_loc ? loc_q :
                       hit_ctrl ? ctrl_rd :
                       hit_flag ? {nv_pkg::ZERO_SEVEN, done_q} :
                       nv_pkg::ZERO_BYTE; // [R10]

  // Unlock sequencer: any other access in between drops the sequence
  always_comb begin
    unl_d = unl_q;
    gap_d = gap_q;
    if (dev_rst) begin
      unl_d = nv_pkg::UNL_IDLE;
      gap_d = '0;
    end else if (take) begin
      gap_d = '0;
      case (unl_q)
        nv_pkg::UNL_IDLE: begin
          unl_d = key1 ? nv_pkg::UNL_KEY1 : nv_pkg::UNL_IDLE; // [R16]
        end
        nv_pkg::UNL_KEY1: begin
          if (key2 && gap_ok) begin
            unl_d = nv_pkg::UNL_ARMED; // [R16]
          end else begin
            unl_d = key1 ? nv_pkg::UNL_KEY1 : nv_pkg::UNL_IDLE;
          end
        end
        nv_pkg::UNL_ARMED: begin
          unl_d = key1 ? nv_pkg::UNL_KEY1 : nv_pkg::UNL_IDLE;
        end
        default: begin
          unl_d = nv_pkg::UNL_IDLE;
        end
      endcase
    end else begin
      if (!gap_ok) begin
        unl_d = nv_pkg::UNL_IDLE; // [R16]
      end else begin
        gap_d = gap_q + 1'b1;
      end
    end
  end

  // Control bits; hardware events win over software writes
  always_comb begin
    fetch_d = fetch_q;
    prog_d = prog_q;
    permit_d = permit_q;
    abort_d = abort_q;
    done_d = done_q;
    cnt_d = '0;
    if (fetch_q) begin
      fetch_d = 1'b0; // [R5] [R13]
    end else if (wr_ctrl && wdat[nv_pkg::CTRL_FETCH]) begin
      fetch_d = 1'b1; // [R5]
    end
    if (prog_q) begin
      cnt_d = cnt_q + 1'b1; // [R19]
    end
    if (dev_rst || prog_end) begin
      prog_d = 1'b0; // [R3] [R5]
    end else if (prog_start) begin
      prog_d = 1'b1; // [R15]
    end
    if (dev_rst) begin
      permit_d = 1'b0;
    end else if (wr_ctrl) begin
      permit_d = wdat[nv_pkg::CTRL_PERMIT]; // [R6] [R18]
    end
    if (prog_cut) begin
      abort_d = 1'b1; // [R7] [R20]
    end else if (wr_ctrl) begin
      abort_d = wdat[nv_pkg::CTRL_ABORT]; // [R7]
    end
    if (prog_end) begin
      done_d = 1'b1; // [R9]
    end else if (wr_flag && !wdat[nv_pkg::FLAG_DONE]) begin
      done_d = 1'b0; // [R9]
    end
    if (dev_rst) begin
      fetch_d = 1'b0;
    end
  end

  // Location and data byte registers
  always_comb begin
    loc_d = loc_q;
    data_d = data_q;
    if (dev_rst) begin
      loc_d = '0; // [R8]
      data_d = '0; // [R8]
    end else begin
      if (wr_loc) begin
        loc_d = wdat;
      end
      if (fetch_q) begin
        data_d = mem[loc_q]; // [R13] [R14]
      end else if (wr_data) begin
        data_d = wdat; // [R14]
      end
    end
  end

  // Wishbone slave: ack one cycle after the strobe, dropped the next
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Read data is zero outside a read answer, so stale bytes never leak
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rdat_q <= nv_pkg::ZERO_WORD;
    end else begin
      rdat_q <= (req && !ack_q && !WB_WE_IN) ? {nv_pkg::ZERO_UPPER, rd_byte} : nv_pkg::ZERO_WORD;
    end
  end

  // Sequencer state
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      unl_q <= nv_pkg::UNL_IDLE;
    end else begin
      unl_q <= unl_d;
    end
  end

  // Idle cycles since the last bus access
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      gap_q <= '0;
    end else begin
      gap_q <= gap_d;
    end
  end

  // Fetch strobe, lives for one cycle only
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= fetch_d;
    end
  end

  // Program-start bit, doubles as busy
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      prog_q <= 1'b0;
    end else begin
      prog_q <= prog_d;
    end
  end

  // Permit is clear after power-up, so no stray program can start
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      permit_q <= 1'b0; // [R6]
    end else begin
      permit_q <= permit_d;
    end
  end

  // Abort flag; power-up has no program to cut, so it starts clear
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_d;
    end
  end

  // Program-done flag
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // Program timer
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Location register
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      loc_q <= '0; // [R8]
    end else begin
      loc_q <= loc_d;
    end
  end

  // Data byte register
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      data_q <= '0; // [R8]
    end else begin
      data_q <= data_d;
    end
  end

  // Program target latched at start, so late register writes cannot corrupt it
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      prog_loc_q <= '0;
      prog_dat_q <= '0;
    end else if (prog_start) begin
      prog_loc_q <= loc_q; // [R11]
      prog_dat_q <= data_q;
    end
  end

  // Array update: a full byte replaces the location, erase is implied
  always_ff @(posedge CORE_CLK_IN) begin
    if (prog_end && !dev_rst) begin
      mem[prog_loc_q] <= prog_dat_q; // [R2]
    end else if (prog_cut) begin
      mem[prog_loc_q] <= nv_pkg::ERASED_BYTE; // [R20]
    end
  end

  // Programmer read port; protection hides contents, CPU path unaffected
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      pgm_out_q <= '0;
    end else if (PROG_RD_IN) begin
      pgm_out_q <= PROTECT_IN ? nv_pkg::ZERO_BYTE : mem[PROG_ADDR_IN]; // [R4]
    end
  end

  assign WB_ACK_OUT = ack_q;
  assign WB_DAT_OUT = rdat_q;
  assign PROG_DATA_OUT = pgm_out_q;
  assign PROGRAM_DONE_OUT = done_q;
  assign BUSY_OUT = prog_q;

endmodule // nv_access

/* nv_access_asserts.sv */
module nv_access_asserts #(
  parameter int PROG_CYC = 8
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic PIN_RESET_IN,
  input wire logic WATCHDOG_RESET_IN,
  input wire logic SUPPLY_DIP_RESET_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  input wire logic PROTECT_IN,
  input wire logic PROG_RD_IN,
  input wire logic [7:0] PROG_DATA_OUT,
  input wire logic PROGRAM_DONE_OUT,
  input wire logic BUSY_OUT
);
  wire logic dev;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  // Busy length is counted, since a long repetition would bloat the checker
  assign dev = PIN_RESET_IN | WATCHDOG_RESET_IN | SUPPLY_DIP_RESET_IN;
  assign cnt_d = BUSY_OUT ? cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_unlock_zero: assert property (WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == 8'h0c |->
    WB_DAT_OUT == 32'h00000000) else $error("unlock port read not zero");
  a_ctrl_upper: assert property (WB_ACK_OUT && !WB_WE_IN && WB_ADR_IN == 8'h08 |->
    WB_DAT_OUT[31:4] == 28'h0000000) else $error("control upper bits not zero");
  a_protect_zero: assert property (PROG_RD_IN && PROTECT_IN |=>
    PROG_DATA_OUT == 8'h00) else $error("protected programmer read not zero");
  a_busy_len: assert property ($fell(BUSY_OUT) && !$past(dev) && $past(RESETN_IN) |->
    cnt_q == PROG_CYC) else $error("program length wrong");
  a_busy_cap: assert property (BUSY_OUT |-> cnt_q < PROG_CYC)
    else $error("program ran too long");
  a_done_set: assert property ($fell(BUSY_OUT) && !$past(dev) && $past(RESETN_IN) |->
    PROGRAM_DONE_OUT) else $error("done flag not set");
  a_done_hold: assert property (PROGRAM_DONE_OUT && !dev &&
    !(WB_ACK_OUT && WB_WE_IN && WB_ADR_IN == 8'h10) |=> PROGRAM_DONE_OUT)
    else $error("done flag cleared by hardware");
  a_reset_abort: assert property (dev |=> !BUSY_OUT)
    else $error("program survived device reset");
  a_start_sticky: assert property (BUSY_OUT && WB_ACK_OUT && WB_WE_IN &&
    WB_ADR_IN == 8'h08 && !dev && cnt_q < PROG_CYC - 1 |=> BUSY_OUT)
    else $error("control write stopped program");
endmodule // nv_access_asserts

bind nv_access nv_access_asserts #(.PROG_CYC(PROG_CYC)) i_nv_access_asserts (.CORE_CLK_IN,
  .RESETN_IN, .PIN_RESET_IN, .WATCHDOG_RESET_IN, .SUPPLY_DIP_RESET_IN, .WB_WE_IN,
  .WB_ADR_IN, .WB_DAT_OUT, .WB_ACK_OUT, .PROTECT_IN, .PROG_RD_IN, .PROG_DATA_OUT,
  .PROGRAM_DONE_OUT, .BUSY_OUT);

/* data_eeprom_access_control_bench.sv */
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module data_eeprom_access_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_n = 0, pin = 0, wdg = 0, dip = 0, cyc = 0, stb = 0, wen = 0;
  logic prot = 0, prd = 0, ack, done, busy;
  logic [7:0] adr = 0, paddr = 0, pdat;
  logic [31:0] wdat = 0, dout, rd;
  int miscompares = 0, num_checks = 0, cycles = 0;
  nv_access #(.PROG_CYC(8)) i_nv_access (.CORE_CLK_IN(clk), .RESETN_IN(rst_n),
    .PIN_RESET_IN(pin), .WATCHDOG_RESET_IN(wdg), .SUPPLY_DIP_RESET_IN(dip), .WB_CYC_IN(cyc),
    .WB_STB_IN(stb), .WB_WE_IN(wen), .WB_ADR_IN(adr), .WB_SEL_IN(4'hf), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(dout), .WB_ACK_OUT(ack), .PROTECT_IN(prot), .PROG_RD_IN(prd),
    .PROG_ADDR_IN(paddr), .PROG_DATA_OUT(pdat), .PROGRAM_DONE_OUT(done), .BUSY_OUT(busy));
  always #12.5 clk = ~clk;
  // Cuts a hang short; a full run needs well under this
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    wen <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    rd = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 8'h00);
    `CHK(nm, e, rd)
  endtask
  // Full unlock sequence with permit set beforehand
  task automatic prog(input logic [7:0] l, input logic [7:0] d);
    wb(1'b1, 8'h04, l);
    wb(1'b1, 8'h00, d);
    wb(1'b1, 8'h08, 8'h04);
    wb(1'b1, 8'h0c, 8'h55);
    wb(1'b1, 8'h0c, 8'haa);
    wb(1'b1, 8'h08, 8'h06);
  endtask
  task automatic fetch(input logic [7:0] l, input logic [7:0] e);
    wb(1'b1, 8'h04, l);
    wb(1'b1, 8'h08, 8'h01);
    rdchk(8'h00, {24'h000000, e}, "fetched");
  endtask
  task automatic t_reset();
    rdchk(8'h00, 32'h0, "data");
    rdchk(8'h04, 32'h0, "loc");
    rdchk(8'h08, 32'h0, "ctrl");
    wb(1'b1, 8'h0c, 8'h55);
    rdchk(8'h0c, 32'h0, "unlock");
    wb(1'b1, 8'h08, 8'hf0);
    rdchk(8'h08, 32'h0, "ctrl hi");
  endtask
  task automatic t_program();
    prog(8'h3c, 8'ha5);
    `CHK("busy", 1'b1, busy)
    wb(1'b1, 8'h08, 8'h00);
    rdchk(8'h08, 32'h2, "busy ctrl");
    while (busy === 1'b1) begin
      @(posedge clk);
    end
    `CHK("done", 1'b1, done)
    rdchk(8'h10, 32'h1, "flag");
    wb(1'b1, 8'h10, 8'h00);
    rdchk(8'h10, 32'h0, "flag clr");
    rdchk(8'h00, 32'ha5, "held");
    wb(1'b1, 8'h00, 8'h00);
    fetch(8'h3c, 8'ha5);
  endtask
  // Wrong key order, then a correct order without permit
  task automatic t_refuse();
    wb(1'b1, 8'h08, 8'h04);
    wb(1'b1, 8'h0c, 8'haa);
    wb(1'b1, 8'h0c, 8'h55);
    wb(1'b1, 8'h08, 8'h06);
    rdchk(8'h08, 32'h4, "bad keys");
    wb(1'b1, 8'h08, 8'h00);
    wb(1'b1, 8'h0c, 8'h55);
    wb(1'b1, 8'h0c, 8'haa);
    wb(1'b1, 8'h08, 8'h02);
    rdchk(8'h08, 32'h0, "no permit");
  endtask
  task automatic t_abort(input int k);
    prog(8'h3c, 8'h11);
    repeat (2) @(posedge clk);
    pin <= (k == 0);
    wdg <= (k == 1);
    dip <= (k == 2);
    @(posedge clk);
    pin <= 1'b0;
    wdg <= 1'b0;
    dip <= 1'b0;
    @(posedge clk);
    rdchk(8'h08, 32'h8, "abort");
    rdchk(8'h04, 32'h0, "loc clr");
    `CHK("no done", 1'b0, done)
    wb(1'b1, 8'h08, 8'h00);
    rdchk(8'h08, 32'h0, "abort clr");
    fetch(8'h3c, 8'hff);
  endtask
  task automatic t_protect(input logic p, input logic [7:0] e);
    prot <= p;
    prd <= 1'b1;
    paddr <= 8'h3c;
    @(posedge clk);
    prd <= 1'b0;
    @(posedge clk);
    `CHK("tool read", e, pdat)
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_program();
    t_refuse();
    for (int k = 0; k < 3; k++) begin
      t_abort(k);
    end
    t_protect(1'b0, 8'hff);
    t_protect(1'b1, 8'h00);
    test_done();
  end
endmodule // data_eeprom_access_control_bench
